/* logic/dbfi_top.sv */
// dbfi_top: read path, address decode, fault capture and the two bank
// sequencers of the dual bank flash interface.
// assumes array macros return read data the cycle after their read enable,
// and that processor-side check and event export are set up by software.
//
// Notes on behaviour
// - each bank holds one to sixteen sectors sharing one datapath
// - erase acts on whole sectors only, never part of a sector
// - program bank: sectors 0-5 16KB, 6 32KB, 7-10 128KB up to 0x9FFFF
// - program bank words are 144 bits including check bits
// - data bank: sixteen 4KB sectors from 0xF0200000 to 0xF020FFFF
// - data bank words are 72 bits including check bits
// - data bank program or erase runs while fetching from program bank
// - no instruction fetch from the data bank, data reads only
// - reads to the idle bank proceed while the other bank is busy
// - built-in sequencers run operations; software starts and sees done
// - pipelined mode overlaps successive fetches
// - every program bank fetch returns 64 data bits with 8 check bits
// - address of an access reported faulty is captured
// - program bank word program nominally 40 us, at most 300 us
// - program bank programmed 144 bits per operation, total under 8 s
// - bank erase erases all sectors at once, sector time, max 4 s
// - data bank word program nominally 47 us, at most 310 us
// - data bank erase at least 0.2 s, at most 8 s
// - bus port reads of data bank allowed, writes refused

`timescale 1ns/1ps
`default_nettype none

module dbfi_top #(
	parameter int unsigned PB_PROG_CYC  = dbfi_pkg::PB_PROG_CYC,
	parameter int unsigned PB_ERASE_CYC = dbfi_pkg::PB_ERASE_CYC,
	parameter int unsigned DB_PROG_CYC  = dbfi_pkg::DB_PROG_CYC,
	parameter int unsigned DB_ERASE_CYC = dbfi_pkg::DB_ERASE_CYC
) (
	input  wire logic                             clk,
	input  wire logic                             sys_rst,
	input  wire logic                             pipe_en,
	input  wire logic                             req_valid,
	output logic                                  req_ready,
	input  wire dbfi_pkg::dbfi_req_t              req,
	output logic                                  rsp_valid,
	output dbfi_pkg::dbfi_rsp_t                   rsp,
	input  wire logic                             ecc_fault,
	input  wire logic                             fault_clr,
	output logic                                  fault_valid,
	output logic [31:0]                           fault_addr,
	input  wire logic                             cmd_valid,
	output logic                                  cmd_ready,
	input  wire dbfi_pkg::dbfi_cmd_t              cmd,
	output logic                                  pb_busy,
	output logic                                  pb_done,
	output logic                                  db_busy,
	output logic                                  db_done,
	output logic                                  pb_rd_en,
	output logic [dbfi_pkg::PB_ROW_W-1:0]         pb_rd_row,
	input  wire logic [dbfi_pkg::PB_WORD_W-1:0]   pb_rd_data,
	output logic                                  pb_prog_en,
	output logic                                  pb_erase_en,
	output logic [dbfi_pkg::PB_ROW_W-1:0]         pb_wr_row,
	output logic [dbfi_pkg::PB_WORD_W-1:0]        pb_wdata,
	output logic [dbfi_pkg::PB_SECTORS-1:0]       pb_erase_mask,
	output logic                                  db_rd_en,
	output logic [dbfi_pkg::DB_ROW_W-1:0]         db_rd_row,
	input  wire logic [dbfi_pkg::DB_WORD_W-1:0]   db_rd_data,
	output logic                                  db_prog_en,
	output logic                                  db_erase_en,
	output logic [dbfi_pkg::DB_ROW_W-1:0]         db_wr_row,
	output logic [dbfi_pkg::DB_WORD_W-1:0]        db_wdata,
	output logic [dbfi_pkg::DB_SECTORS-1:0]       db_erase_mask
);
	import dbfi_pkg::*;

	typedef struct packed {
		logic        s1_v;      // read in flight to the array
		dbfi_bank_t  s1_bank;
		logic        s1_err;
		logic        s1_half;   // which 64-bit half of a wide word
		logic [31:0] s1_addr;
		logic        rsp_v;
		dbfi_rsp_t   rsp;
		logic [31:0] rsp_addr;  // address of the last answered read
		logic        fault_v;
		logic [31:0] fault_addr;
	} dbfi_top_st_t;

	dbfi_top_st_t st_ff;
	dbfi_top_st_t nxt_st;

	logic       in_pb;
	logic       in_db;
	dbfi_bank_t req_bank;
	logic       req_err;
	logic       stall;
	logic       slot_free;
	logic       take;
	logic       cmd_conflict;
	logic       tgt_busy;
	logic       pb_start;
	logic       db_start;
	logic [FETCH_W-1:0] sel_data;
	logic [ECC_W-1:0]   sel_ecc;
	logic [SECT_W-1:0]  cmd_sect;

	// address decode; program bank starts at zero so only the top is checked
	always_comb begin
		in_pb    = (req.addr <= PB_LAST);
		in_db    = (req.addr >= DB_BASE) && (req.addr <= DB_LAST);
		req_bank = in_db ? BANK_DATA : BANK_PROG;
		// bus writes never reach flash; fetches from the data bank fault
		req_err  = req.write || (req.instr && in_db) || !(in_pb || in_db);
	end

	// a busy bank holds off its reads; the other bank is unaffected
	assign stall     = !req_err && (in_db ? db_busy : pb_busy);
	// without pipelining only one read is in flight at a time
	assign slot_free = pipe_en || (!st_ff.s1_v && !st_ff.rsp_v);
	assign req_ready = slot_free && !stall;
	assign take      = req_valid && req_ready;

	// array read strobes go out in the cycle the request is taken
	assign pb_rd_en  = take && !req_err && in_pb;
	assign pb_rd_row = req.addr[19:4];
	assign db_rd_en  = take && !req_err && in_db;
	assign db_rd_row = req.addr[15:3];

	// half select of the wide word; check byte travels with its data
	always_comb begin
		if (st_ff.s1_bank == BANK_DATA) begin
			sel_data = db_rd_data[FETCH_W-1:0];
			sel_ecc  = db_rd_data[DB_WORD_W-1:FETCH_W];
		end else if (st_ff.s1_half) begin
			sel_data = pb_rd_data[2*FETCH_W-1:FETCH_W];
			sel_ecc  = pb_rd_data[PB_WORD_W-1:2*FETCH_W+ECC_W];
		end else begin
			sel_data = pb_rd_data[FETCH_W-1:0];
			sel_ecc  = pb_rd_data[2*FETCH_W+ECC_W-1:2*FETCH_W];
		end
	end

	// commands wait for reads to the same bank, which keeps array access
	// and the sequencer from overlapping on one bank
	always_comb begin
		tgt_busy     = (cmd.bank == BANK_DATA) ? db_busy : pb_busy;
		cmd_conflict = (req_valid && !req_err && (req_bank == cmd.bank))
		             || (st_ff.s1_v && !st_ff.s1_err && (st_ff.s1_bank == cmd.bank));
		cmd_ready    = !tgt_busy && !cmd_conflict;
		pb_start     = cmd_valid && cmd_ready && (cmd.bank == BANK_PROG);
		db_start     = cmd_valid && cmd_ready && (cmd.bank == BANK_DATA);
		cmd_sect     = (cmd.bank == BANK_DATA) ? cmd.addr[15:12] : pb_sector(cmd.addr);
	end

	// read pipeline and fault capture
	always_comb begin
		nxt_st      = st_ff;
		nxt_st.s1_v = take;
		if (take) begin
			nxt_st.s1_bank = req_bank;
			nxt_st.s1_err  = req_err;
			nxt_st.s1_half = req.addr[3];
			nxt_st.s1_addr = req.addr;
		end
		nxt_st.rsp_v = st_ff.s1_v;
		if (st_ff.s1_v) begin
			nxt_st.rsp_addr = st_ff.s1_addr;
			if (st_ff.s1_err) begin
				nxt_st.rsp = '{data: '0, ecc: '0, err: 1'b1};
			end else begin
				nxt_st.rsp = '{data: sel_data, ecc: sel_ecc, err: 1'b0};
			end
		end
		// the processor flags a fault after checking the last answer;
		// a new fault wins over a clear in the same cycle
		if (fault_clr) begin
			nxt_st.fault_v = 1'b0;
		end
		if (ecc_fault) begin
			nxt_st.fault_v    = 1'b1;
			nxt_st.fault_addr = st_ff.rsp_addr;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rsp_valid   = st_ff.rsp_v;
	assign rsp         = st_ff.rsp;
	assign fault_valid = st_ff.fault_v;
	assign fault_addr  = st_ff.fault_addr;

	// program bank sequencer, 144 bits per program operation
	dbfi_seq #(
		.DATA_W    (PB_WORD_W),
		.ROW_W     (PB_ROW_W),
		.NSECT     (PB_SECTORS),
		.PROG_CYC  (PB_PROG_CYC),
		.ERASE_CYC (PB_ERASE_CYC),
		.PROG_MAX  (PB_PROG_MAX_CYC)
	) u_pb_seq (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.start      (pb_start),
		.op         (cmd.op),
		.row        (cmd.addr[19:4]),
		.wdata      (cmd.wdata),
		.sect       (cmd_sect),
		.busy       (pb_busy),
		.done       (pb_done),
		.prog_en    (pb_prog_en),
		.erase_en   (pb_erase_en),
		.arr_row    (pb_wr_row),
		.arr_wdata  (pb_wdata),
		.erase_mask (pb_erase_mask)
	);

	// data bank sequencer, independent of the program bank
	dbfi_seq #(
		.DATA_W    (DB_WORD_W),
		.ROW_W     (DB_ROW_W),
		.NSECT     (DB_SECTORS),
		.PROG_CYC  (DB_PROG_CYC),
		.ERASE_CYC (DB_ERASE_CYC),
		.PROG_MAX  (DB_PROG_MAX_CYC)
	) u_db_seq (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.start      (db_start),
		.op         (cmd.op),
		.row        (cmd.addr[15:3]),
		.wdata      (cmd.wdata[DB_WORD_W-1:0]),
		.sect       (cmd_sect),
		.busy       (db_busy),
		.done       (db_done),
		.prog_en    (db_prog_en),
		.erase_en   (db_erase_en),
		.arr_row    (db_wr_row),
		.arr_wdata  (db_wdata),
		.erase_mask (db_erase_mask)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_fetch_db_err;
		take && req.instr && in_db |-> ##2 rsp_valid && rsp.err && (rsp.data == '0);
	endproperty
	a_fetch_db_err: assert property (p_fetch_db_err) else $error("data bank fetch not refused");

	property p_write_refused;
		take && req.write |-> !pb_rd_en && !db_rd_en ##2 rsp_valid && rsp.err;
	endproperty
	a_write_refused: assert property (p_write_refused) else $error("bus write not refused");

	property p_busy_stall;
		req_valid && !req_err && in_pb && pb_busy |-> !req_ready && !pb_rd_en;
	endproperty
	a_busy_stall: assert property (p_busy_stall) else $error("read taken from busy bank");

	property p_other_bank;
		req_valid && !req_err && in_pb && !pb_busy && db_busy && slot_free |-> req_ready;
	endproperty
	a_other_bank: assert property (p_other_bank) else $error("idle bank read held off");

	// check byte is taken straight from the array word, not from the select mux
	property p_ecc_return;
		take && !req_err && in_pb |-> ##2 rsp_valid && !rsp.err
			&& (rsp.ecc == ($past(st_ff.s1_half) ? $past(pb_rd_data[143:136])
			                                     : $past(pb_rd_data[135:128])));
	endproperty
	a_ecc_return: assert property (p_ecc_return) else $error("check byte not returned");

	property p_fault_capture;
		ecc_fault |=> fault_valid && (fault_addr == $past(st_ff.rsp_addr));
	endproperty
	a_fault_capture: assert property (p_fault_capture) else $error("fault address lost");

	// two takes in a row must give two answers in a row
	property p_pipelined;
		(pipe_en && take) ##1 take |-> ##1 rsp_valid ##1 rsp_valid;
	endproperty
	a_pipelined: assert property (p_pipelined) else $error("pipelined answers not back to back");

	property p_sector_map;
		pb_start && (cmd.op == OP_ERASE_SECT) && (cmd.addr == PB_S6_BASE) |-> cmd_sect == PB_S6_NUM;
	endproperty
	a_sector_map: assert property (p_sector_map) else $error("sector decode wrong");

	c_fetch_db: cover property (take && req.instr && in_db);
	c_back2back: cover property (pipe_en && take ##1 take);
	c_read_while_erase: cover property (db_erase_en && pb_rd_en);

endmodule : dbfi_top

`default_nettype wire

/* logic/dbfi_pkg.sv */
// dbfi_pkg: constants, address map, timing and carrier types of the
// dual bank flash interface.
// assumes a single 250 MHz clock; array macros sit outside the block.

`default_nettype none

package dbfi_pkg;

	// clock rate used to turn times into cycle counts
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned CLK_HZ  = CLK_MHZ * 1000000;

	// word geometry of the two banks and of one fetch
	localparam int PB_WORD_W = 144;
	localparam int DB_WORD_W = 72;
	localparam int FETCH_W   = 64;
	localparam int ECC_W     = 8;
	localparam int PB_ROW_W  = 16;   // byte address bits 19:4
	localparam int DB_ROW_W  = 13;   // byte address bits 15:3
	localparam int SECT_W    = 4;

	// sector counts, both within one to sixteen
	localparam int PB_SECTORS = 11;
	localparam int DB_SECTORS = 16;

	// address map
	localparam logic [31:0] PB_LAST    = 32'h0009_FFFF;
	localparam logic [31:0] PB_S6_BASE = 32'h0001_8000;
	localparam logic [31:0] PB_S7_BASE = 32'h0002_0000;
	localparam logic [31:0] DB_BASE    = 32'hF020_0000;
	localparam logic [31:0] DB_LAST    = 32'hF020_FFFF;
	localparam logic [3:0]  PB_S6_NUM  = 4'h6;

	// program and erase times in their own units
	localparam int unsigned PB_PROG_NOM_US  = 40;
	localparam int unsigned PB_PROG_MAX_US  = 300;
	localparam int unsigned PB_ERASE_MIN_MS = 30;
	localparam int unsigned PB_ERASE_MAX_S  = 4;
	localparam int unsigned PB_TOTAL_MAX_S  = 8;
	localparam int unsigned DB_PROG_NOM_US  = 47;
	localparam int unsigned DB_PROG_MAX_US  = 310;
	localparam int unsigned DB_ERASE_MIN_MS = 200;
	localparam int unsigned DB_ERASE_MAX_S  = 8;

	// derived cycle counts; nominal and least times, longest times as bounds
	localparam int unsigned PB_PROG_CYC      = PB_PROG_NOM_US * CLK_MHZ;
	localparam int unsigned PB_PROG_MAX_CYC  = PB_PROG_MAX_US * CLK_MHZ;
	localparam int unsigned PB_ERASE_CYC     = PB_ERASE_MIN_MS * (CLK_HZ / 1000);
	localparam int unsigned PB_ERASE_MAX_CYC = PB_ERASE_MAX_S * CLK_HZ;
	localparam int unsigned DB_PROG_CYC      = DB_PROG_NOM_US * CLK_MHZ;
	localparam int unsigned DB_PROG_MAX_CYC  = DB_PROG_MAX_US * CLK_MHZ;
	localparam int unsigned DB_ERASE_CYC     = DB_ERASE_MIN_MS * (CLK_HZ / 1000);
	localparam int unsigned DB_ERASE_MAX_CYC = DB_ERASE_MAX_S * CLK_HZ;

	typedef enum logic [1:0] {
		OP_PROG       = 2'b00,
		OP_ERASE_SECT = 2'b01,
		OP_ERASE_BANK = 2'b10
	} dbfi_op_t;

	typedef enum logic {
		BANK_PROG = 1'b0,
		BANK_DATA = 1'b1
	} dbfi_bank_t;

	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_PULSE = 2'b01,
		SEQ_DONE  = 2'b10
	} dbfi_seq_state_t;

	typedef struct packed {
		logic [31:0] addr;
		logic        instr;
		logic        write;
	} dbfi_req_t;

	typedef struct packed {
		logic [FETCH_W-1:0] data;
		logic [ECC_W-1:0]   ecc;
		logic               err;
	} dbfi_rsp_t;

	typedef struct packed {
		dbfi_op_t             op;
		dbfi_bank_t           bank;
		logic [31:0]          addr;
		logic [PB_WORD_W-1:0] wdata;
	} dbfi_cmd_t;

	// program bank sector of a byte address inside the bank
	function automatic logic [SECT_W-1:0] pb_sector(input logic [31:0] addr);
		logic [SECT_W-1:0] s;
		if (addr < PB_S6_BASE) begin
			s = addr[17:14];
		end else if (addr < PB_S7_BASE) begin
			s = PB_S6_NUM;
		end else begin
			s = PB_S6_NUM + {1'b0, addr[19:17]};
		end
		return s;
	endfunction : pb_sector

endpackage : dbfi_pkg

`default_nettype wire

/* logic/dbfi_seq.sv */
// dbfi_seq: program / erase sequencer for one flash bank.
// assumes start only while busy is low; array acts on the enables.

`timescale 1ns/1ps
`default_nettype none

module dbfi_seq #(
	parameter int          DATA_W  = 144,
	parameter int          ROW_W   = 16,
	parameter int          NSECT   = 11,
	parameter int unsigned PROG_CYC  = 10000,
	parameter int unsigned ERASE_CYC = 7500000,
	parameter int unsigned PROG_MAX  = 75000
) (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   start,
	input  wire dbfi_pkg::dbfi_op_t     op,
	input  wire logic [ROW_W-1:0]       row,
	input  wire logic [DATA_W-1:0]      wdata,
	input  wire logic [3:0]             sect,
	output logic                        busy,
	output logic                        done,
	output logic                        prog_en,
	output logic                        erase_en,
	output logic [ROW_W-1:0]            arr_row,
	output logic [DATA_W-1:0]           arr_wdata,
	output logic [NSECT-1:0]            erase_mask
);
	import dbfi_pkg::*;

	typedef struct packed {
		dbfi_seq_state_t  state;
		dbfi_op_t         op;
		logic [31:0]      cnt;
		logic [ROW_W-1:0] row;
		logic [DATA_W-1:0] data;
		logic [NSECT-1:0] mask;
	} dbfi_seq_st_t;

	dbfi_seq_st_t st_ff;
	dbfi_seq_st_t nxt_st;
	logic [NSECT-1:0] mask_w;

	// whole bank selects every sector at once, else exactly one sector
	for (genvar i = 0; i < NSECT; i++) begin : g_mask
		assign mask_w[i] = (op == OP_ERASE_BANK) || (sect == 4'(i));
	end

	// one timed pulse per operation, then a one-cycle done
	always_comb begin
		nxt_st = st_ff;
		case (st_ff.state)
			SEQ_IDLE: begin
				if (start) begin
					nxt_st.state = SEQ_PULSE;
					nxt_st.op    = op;
					nxt_st.row   = row;
					nxt_st.data  = wdata;
					nxt_st.mask  = mask_w;
					nxt_st.cnt   = (op == OP_PROG) ? PROG_CYC - 1 : ERASE_CYC - 1;
				end
			end
			SEQ_PULSE: begin
				if (st_ff.cnt == 32'h0000_0000) begin
					nxt_st.state = SEQ_DONE;
				end else begin
					nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
				end
			end
			SEQ_DONE: nxt_st.state = SEQ_IDLE;
			default:  nxt_st.state = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign busy       = (st_ff.state != SEQ_IDLE);
	assign done       = (st_ff.state == SEQ_DONE);
	assign prog_en    = (st_ff.state == SEQ_PULSE) && (st_ff.op == OP_PROG);
	assign erase_en   = (st_ff.state == SEQ_PULSE) && (st_ff.op != OP_PROG);
	assign arr_row    = st_ff.row;
	assign arr_wdata  = st_ff.data;
	assign erase_mask = st_ff.mask;

	// helper: length of the current program pulse
	logic [31:0] plen_ff;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			plen_ff <= 32'h0000_0000;
		end else begin
			plen_ff <= prog_en ? plen_ff + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_prog_len;
		$fell(prog_en) |-> (plen_ff == PROG_CYC) && (plen_ff <= PROG_MAX);
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("program pulse length wrong");

	property p_done_after_pulse;
		$fell(busy) |-> $past(done) && !prog_en && !erase_en;
	endproperty
	a_done_after_pulse: assert property (p_done_after_pulse) else $error("busy fell w/o done");

	property p_erase_mask;
		erase_en |-> ((st_ff.op == OP_ERASE_BANK) ? (&erase_mask) : $onehot(erase_mask));
	endproperty
	a_erase_mask: assert property (p_erase_mask) else $error("erase mask not sector aligned");

	property p_start_busy;
		start && !busy |=> busy ##1 (prog_en || erase_en);
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start did not launch");

	c_bank_erase: cover property (erase_en && (&erase_mask));

endmodule : dbfi_seq

`default_nettype wire

/* sim/dbfi_array_model.sv */
// dbfi_array_model: behavioural flash arrays behind the two read ports.
// assumes the interface samples read data one cycle after its read enable.
`timescale 1ns/1ps
`default_nettype none

module dbfi_array_model (
	input  wire logic                               clk,
	input  wire logic                               pb_rd_en,
	input  wire logic [dbfi_pkg::PB_ROW_W-1:0]      pb_rd_row,
	input  wire logic                               db_rd_en,
	input  wire logic [dbfi_pkg::DB_ROW_W-1:0]      db_rd_row,
	output logic      [dbfi_pkg::PB_WORD_W-1:0]     pb_rd_data,
	output logic      [dbfi_pkg::DB_WORD_W-1:0]     db_rd_data
);
	import dbfi_pkg::*;

	initial begin
		pb_rd_data = '0;
		db_rd_data = '0;
	end

	// word follows the enable by one cycle; otherwise the lines toggle so a
	// late sample by the interface never sees a stale word
	always @(posedge clk) begin
		pb_rd_data <= pb_rd_en ? {pb_rd_row ^ 16'hA5C3, ~{4{pb_rd_row}}, {4{pb_rd_row}}}
			: ~pb_rd_data;
		db_rd_data <= db_rd_en ? {db_rd_row[7:0] ^ 8'h3C, {4{3'h0, db_rd_row}}}
			: ~db_rd_data;
	end
endmodule : dbfi_array_model

`default_nettype wire

/* sim/tb.sv */
// tb: self-checking bench of the dual bank flash interface.
// assumes dbfi_array_model stands in for the arrays; counts are shortened.
`timescale 1ns/1ps
`default_nettype none

module tb;
	import dbfi_pkg::*;
	localparam logic [143:0] W = 144'h0123456789ABCDEFFEDCBA98765432105A3C;
	logic clk, sys_rst, pipe_en, req_valid, req_ready, rsp_valid, ecc_fault, fault_clr;
	logic fault_valid, cmd_valid, cmd_ready, pb_busy, pb_done, db_busy, db_done;
	logic pb_rd_en, pb_prog_en, pb_erase_en, db_rd_en, db_prog_en, db_erase_en;
	logic [31:0] fault_addr;
	logic [PB_ROW_W-1:0] pb_rd_row, pb_wr_row;
	logic [DB_ROW_W-1:0] db_rd_row, db_wr_row;
	logic [PB_WORD_W-1:0] pb_rd_data, pb_wdata;
	logic [DB_WORD_W-1:0] db_rd_data, db_wdata;
	logic [PB_SECTORS-1:0] pb_erase_mask;
	logic [DB_SECTORS-1:0] db_erase_mask;
	dbfi_req_t req;
	dbfi_rsp_t rsp;
	dbfi_cmd_t cmd;
	int n_fail, n_checks, last_wait;

	// short pulse counts keep the run brief; expectations use the same values
	dbfi_top #(.PB_PROG_CYC(4), .PB_ERASE_CYC(8), .DB_PROG_CYC(4), .DB_ERASE_CYC(8)) dbfi_top_i (
		.clk, .sys_rst, .pipe_en, .req_valid, .req_ready, .req, .rsp_valid, .rsp,
		.ecc_fault, .fault_clr, .fault_valid, .fault_addr, .cmd_valid, .cmd_ready, .cmd,
		.pb_busy, .pb_done, .db_busy, .db_done, .pb_rd_en, .pb_rd_row, .pb_rd_data,
		.pb_prog_en, .pb_erase_en, .pb_wr_row, .pb_wdata, .pb_erase_mask, .db_rd_en,
		.db_rd_row, .db_rd_data, .db_prog_en, .db_erase_en, .db_wr_row, .db_wdata,
		.db_erase_mask);
	dbfi_array_model dbfi_array_model_i (.clk, .pb_rd_en, .pb_rd_row, .db_rd_en,
		.db_rd_row, .pb_rd_data, .db_rd_data);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [143:0] got, input logic [143:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic print_verdict;
		if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict

	// answer the array model should produce, worked out from the pairing
	function automatic dbfi_rsp_t exp_rd(input logic [31:0] a);
		dbfi_rsp_t r;
		logic [15:0] pr;
		logic [12:0] dr;
		pr = a[19:4];
		dr = a[15:3];
		r.err = 1'b0;
		if (a[31]) begin
			r.data = {4{3'h0, dr}};
			r.ecc = dr[7:0] ^ 8'h3C;
		end else begin
			r.data = a[3] ? ~{4{pr}} : {4{pr}};
			r.ecc = a[3] ? pr[15:8] ^ 8'hA5 : pr[7:0] ^ 8'hC3;
		end
		return r;
	endfunction : exp_rd

	// one read: hold the request until taken, answer counted from the take
	task automatic rd(input logic [31:0] a, input logic ins, input logic wr, output dbfi_rsp_t r);
		int n;
		req_valid <= 1'b1;
		req <= '{addr: a, instr: ins, write: wr};
		n = 0;
		do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 50);
		last_wait = n;
		req_valid <= 1'b0;
		n = 0;
		do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 10);
		chk(n, 2);
		r = rsp;
	endtask : rd

	task automatic cmd_start(input dbfi_op_t op, input dbfi_bank_t b, input logic [31:0] a);
		int n;
		cmd_valid <= 1'b1;
		cmd <= '{op: op, bank: b, addr: a, wdata: W};
		n = 0;
		do begin @(posedge clk); n++; end while (cmd_ready !== 1'b1 && n < 50);
		cmd_valid <= 1'b0;
		chk(n, 1);
	endtask : cmd_start

	// run one command and judge enable length, done timing, data or mask
	task automatic op_run(input dbfi_op_t op, input dbfi_bank_t b, input logic [31:0] a,
		input logic [15:0] m, input int n);
		int on, t;
		logic en;
		cmd_start(op, b, a);
		on = 0;
		for (t = 1; t < 40; t++) begin
			@(posedge clk);
			if (t == 1) chk(b ? db_busy : pb_busy, 1);
			en = (op == OP_PROG) ? (b ? db_prog_en : pb_prog_en) : (b ? db_erase_en : pb_erase_en);
			if (en === 1'b1) on++;
			if (en === 1'b1 && on == 1) begin
				if (op == OP_PROG) chk(b ? 144'(db_wdata) : pb_wdata, b ? 144'(W[71:0]) : W);
				else chk(b ? db_erase_mask : 16'(pb_erase_mask), m);
				if (op == OP_PROG) chk(b ? 16'(db_wr_row) : pb_wr_row, b ? 16'(a[15:3]) : a[19:4]);
			end
			if ((b ? db_done : pb_done) === 1'b1) break;
		end
		chk(on, n);
		chk(t, n + 1);
	endtask : op_run

	task automatic t_reads;
		logic [31:0] al[7] = '{32'h0, 32'h0001_7FF8, 32'h0001_8008, 32'h0009_FFF8,
			DB_BASE, DB_LAST - 32'h7, 32'hF020_1238};
		dbfi_rsp_t r;
		foreach (al[i]) begin
			rd(al[i], ~al[i][31], 1'b0, r);
			chk(r, exp_rd(al[i]));
		end
	endtask : t_reads

	// refused accesses: fetch from data bank, out of map, bus writes
	task automatic t_errs;
		logic [33:0] ev[5] = '{{DB_BASE + 32'h10, 2'b10}, {32'h000A_0000, 2'b00},
			{DB_BASE, 2'b01}, {32'hF021_0000, 2'b00}, {32'h0000_0100, 2'b01}};
		dbfi_rsp_t r;
		foreach (ev[i]) begin
			rd(ev[i][33:2], ev[i][1], ev[i][0], r);
			chk(r, 73'h1);
		end
	endtask : t_errs

	task automatic t_pipe;
		logic [31:0] a[3] = '{32'h0000_0100, 32'h0000_0108, 32'h0002_0010};
		int t, k, i;
		pipe_en <= 1'b1;
		req_valid <= 1'b1;
		req <= '{addr: a[0], instr: 1'b1, write: 1'b0};
		i = 0;
		k = 0;
		for (t = 0; t < 12; t++) begin
			@(posedge clk);
			if (rsp_valid === 1'b1 && k < 3) begin
				chk(rsp, exp_rd(a[k]));
				chk(t, k + 2);
				k++;
			end
			if (i < 3 && req_ready === 1'b1) begin
				i++;
				if (i < 3) req <= '{addr: a[i], instr: 1'b1, write: 1'b0};
				else req_valid <= 1'b0;
			end
		end
		chk(k, 3);
		pipe_en <= 1'b0;
	endtask : t_pipe

	task automatic t_ops;
		op_run(OP_PROG, BANK_PROG, 32'h0000_0040, 16'h0, 4);
		op_run(OP_ERASE_SECT, BANK_PROG, 32'h0001_8000, 16'h0040, 8);
		op_run(OP_ERASE_SECT, BANK_PROG, 32'h0001_4000, 16'h0020, 8);
		op_run(OP_ERASE_SECT, BANK_PROG, 32'h0008_0000, 16'h0400, 8);
		op_run(OP_ERASE_BANK, BANK_PROG, 32'h0, 16'h07FF, 8);
		op_run(OP_PROG, BANK_DATA, DB_BASE + 32'h8, 16'h0, 4);
		op_run(OP_ERASE_SECT, BANK_DATA, 32'hF020_F000, 16'h8000, 8);
		op_run(OP_ERASE_BANK, BANK_DATA, DB_BASE, 16'hFFFF, 8);
	endtask : t_ops

	// fetch from the program bank while the data bank erases
	task automatic t_overlap;
		dbfi_rsp_t r;
		int n;
		cmd_start(OP_ERASE_SECT, BANK_DATA, DB_BASE);
		@(posedge clk);
		rd(32'h0000_0200, 1'b1, 1'b0, r);
		chk(r, exp_rd(32'h0000_0200));
		chk(last_wait, 1);
		chk(db_busy, 1);
		n = 0;
		do begin @(posedge clk); n++; end while (db_done !== 1'b1 && n < 20);
		chk(db_done, 1);
	endtask : t_overlap

	task automatic t_stall;
		dbfi_rsp_t r;
		cmd_start(OP_ERASE_BANK, BANK_PROG, 32'h0);
		@(posedge clk);
		rd(32'h0000_0300, 1'b0, 1'b0, r);
		chk(last_wait > 7, 1);
		chk(r, exp_rd(32'h0000_0300));
	endtask : t_stall

	// fault address captured, kept over a clean read, then cleared
	task automatic t_fault;
		dbfi_rsp_t r;
		rd(32'h0004_1230, 1'b0, 1'b0, r);
		// processor has check and event export enabled and flags the last answer
		ecc_fault <= 1'b1;
		@(posedge clk);
		ecc_fault <= 1'b0;
		@(posedge clk);
		chk(fault_valid, 1);
		chk(fault_addr, 32'h0004_1230);
		rd(32'h0000_0500, 1'b0, 1'b0, r);
		chk(fault_addr, 32'h0004_1230);
		fault_clr <= 1'b1;
		@(posedge clk);
		fault_clr <= 1'b0;
		@(posedge clk);
		chk(fault_valid, 0);
		// a fault in the same cycle as a clear must win
		ecc_fault <= 1'b1;
		fault_clr <= 1'b1;
		@(posedge clk);
		ecc_fault <= 1'b0;
		fault_clr <= 1'b0;
		@(posedge clk);
		chk(fault_valid, 1);
	endtask : t_fault

	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		print_verdict();
	end

	initial begin
		sys_rst = 1'b1;
		pipe_en = 1'b0;
		req_valid = 1'b0;
		req = '0;
		ecc_fault = 1'b0;
		fault_clr = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		n_fail = 0;
		n_checks = 0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk({pb_busy, db_busy, rsp_valid, fault_valid}, 4'h0);
		t_reads();
		t_errs();
		t_pipe();
		t_ops();
		t_overlap();
		t_stall();
		t_fault();
		print_verdict();
	end
endmodule : tb

`default_nettype wire
